// >>> verilog/pfsws_pkg.sv
// Shared constants, register map and state codes of the program flash sequencer
// What this block does
// R1: Fetch copies one pointed byte into latch
// R2: Pointer bit 0 picks high or low byte
// R3: Pointer may auto-step after a fetch
// R4: Erase clears 64-byte block, pointer bits 21:6
// R5: No word erase; nothing larger than block
// R6: Software sets erase selects before erasing
// R7: Software disables interrupts, unlocks, sets go
// R8: Go with erase-select starts row erase
// R9: Core halted; internal timer ends cycle
// R10: Row erase stalls core about 2 ms
// R11: Block program stalls core about 2 ms
// R12: Smallest programmed unit is 8 bytes
// R13: Eight holding registers; loads never touch array
// R14: Software loads eight bytes, then starts write
// R15: Pointer must sit inside target eight bytes
// R16: Software sets write selects, erase clear
// R17: Software row update: read, erase, program, verify
// R18: Pin or watchdog reset mid-write sets abort
// R19: Software verifies and reprograms after abort
// R20: Go only settable; hardware clears on completion
// R21: Done flag sticky until software clears
// R22: Pointer 2:0 holding slot, 21:3 block
// R23: Pointer kept, post-inc, post-dec or pre-inc
// R24: Go needs unlock writes just before it
package pfsws_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_US = 2000;
  localparam int PROG_CYCLES = PROG_TIME_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================
  // Geometry
  localparam int PTR_W = 22;
  localparam int HOLD_N = 8;
  localparam int ERASE_WORDS = 32;
  localparam int PROG_WORDS = 4;
  localparam int MEM_AW = 15;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_POINTER = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_UNLOCK = 8'h0C;
  localparam logic [7:0] OFS_TABLE_OP = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ==========================================================
  // nvm_control fields
  localparam int CTL_SPACE = 7;
  localparam int CTL_CFG = 6;
  localparam int CTL_ERASE = 4;
  localparam int CTL_ABORT = 3;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_GO = 1;

  // ==========================================================
  // Table op command and status fields
  localparam int OP_LOAD = 0;
  localparam int OP_MODE_LSB = 1;
  localparam logic [1:0] MODE_KEEP = 2'h0;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [1:0] MODE_POSTDEC = 2'h2;
  localparam logic [1:0] MODE_PREINC = 2'h3;
  localparam int ST_DONE = 0;
  localparam int ST_BUSY = 1;

  // ==========================================================
  // Unlock keys and stages
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [1:0] UNL_NONE = 2'h0;
  localparam logic [1:0] UNL_HALF = 2'h1;
  localparam logic [1:0] UNL_OPEN = 2'h2;

  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_FETCH_LATCH = 5'b00100,
    ST_WR_ARRAY = 5'b01000,
    ST_WAIT = 5'b10000
  } pfsws_state_type;

endpackage

// >>> verilog/pfsws_flash_array.sv
// Word-wide program flash array with registered read port
`timescale 1ns/1ps
module pfsws_flash_array #(
  parameter int AW = 15,
  parameter int DW = 16
) (
  input wire logic core_clk,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_r,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data
);

  // ==========================================================
  // Storage; contents undefined until erased or programmed
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= mem[rd_addr];
  end

endmodule

// >>> verilog/pfsws_prog_timer.sv
// Programming timer that ends each long erase or write
`timescale 1ns/1ps
module pfsws_prog_timer #(
  parameter int CYCLES = 250000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  output logic done_r
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic run_r;
  logic run_nxt;
  logic done_nxt;

  // ==========================================================
  // Count
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done_nxt = 1'b0;
    if (abort) begin
      run_nxt = 1'b0;
    end else if (start) begin
      cnt_nxt = '0;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r == LAST) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done_r <= done_nxt;
    end
  end

endmodule

// >>> verilog/pfsws_top.sv
// Program flash self-write sequencer with AHB-Lite register slave
`timescale 1ns/1ps
module pfsws_top
  import pfsws_pkg::*;
#(
  parameter int PROG_CYCLES_P = pfsws_pkg::PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_timeout,
  output logic core_stall
);
  import pfsws_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic down);
    logic [PTR_W-2:0] low;
    low = down ? p[PTR_W-2:0] - 21'h000001 : p[PTR_W-2:0] + 21'h000001;
    ptr_step = {p[PTR_W-1], low};
  endfunction

  // ==========================================================
  // State
  pfsws_state_type state_r, state_nxt;
  logic [PTR_W-1:0] ptr_r, ptr_nxt;
  logic [PTR_W-1:0] op_addr_r, op_addr_nxt;
  logic [PTR_W-1:0] base_r, base_nxt;
  logic [7:0] latch_r, latch_nxt;
  logic [7:0] hold_r [0:HOLD_N-1];
  logic [7:0] hold_nxt [0:HOLD_N-1];
  logic space_r, space_nxt;
  logic cfg_r, cfg_nxt;
  logic erase_sel_r, erase_sel_nxt;
  logic permit_r, permit_nxt;
  logic abort_r, abort_nxt;
  logic go_r, go_nxt;
  logic done_r, done_nxt;
  logic erase_op_r, erase_op_nxt;
  logic start_r, start_nxt;
  logic [1:0] unlock_r, unlock_nxt;
  logic [4:0] idx_r, idx_nxt;
  logic pend_r, pend_nxt;
  logic pend_wr_r, pend_wr_nxt;
  logic act_done_r, act_done_nxt;
  logic [7:0] addr_q_r, addr_q_nxt;
  logic hreadyout_r, hreadyout_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;

  // Pin inputs pass two flops; only the second stage is read
  logic ext_s1_r, ext_s2_r, wdt_s1_r, wdt_s2_r;

  logic [15:0] mem_rd_data;
  logic mem_wr_en;
  logic [MEM_AW-1:0] mem_wr_addr;
  logic [15:0] mem_wr_data;
  logic timer_done;
  logic abort_evt;
  logic act_fire;
  logic [PTR_W-1:0] eff;
  logic [1:0] mode;
  logic [PTR_W-2:0] word_addr;
  logic last_word;

  // Reset events only count while a long cycle runs
  assign abort_evt = go_r & (~ext_s2_r | wdt_s2_r); // R18

  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign core_stall = go_r; // R9

  // ==========================================================
  // Array write address and data
  always_comb begin
    mem_wr_en = (state_r == ST_WR_ARRAY);
    if (erase_op_r) begin
      word_addr = {base_r[PTR_W-1:6], idx_r}; // R4
      mem_wr_data = ERASED_WORD;
      last_word = (idx_r == 5'(ERASE_WORDS - 1)); // R5
    end else begin
      word_addr = {base_r[PTR_W-1:3], idx_r[1:0]}; // R22
      mem_wr_data = {hold_r[{idx_r[1:0], 1'b1}], hold_r[{idx_r[1:0], 1'b0}]}; // R12
      last_word = (idx_r == 5'(PROG_WORDS - 1));
    end
    mem_wr_addr = word_addr[MEM_AW-1:0];
  end

  pfsws_flash_array #(
    .AW(MEM_AW),
    .DW(16)
  ) u_array (
    .core_clk(core_clk),
    .rd_addr(op_addr_r[MEM_AW:1]),
    .rd_data_r(mem_rd_data),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data)
  );

  pfsws_prog_timer #(
    .CYCLES(PROG_CYCLES_P)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(start_r),
    .abort(abort_evt),
    .done_r(timer_done)
  );

  // ==========================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    ptr_nxt = ptr_r;
    op_addr_nxt = op_addr_r;
    base_nxt = base_r;
    latch_nxt = latch_r;
    hold_nxt = hold_r;
    space_nxt = space_r;
    cfg_nxt = cfg_r;
    erase_sel_nxt = erase_sel_r;
    permit_nxt = permit_r;
    abort_nxt = abort_r;
    go_nxt = go_r;
    done_nxt = done_r;
    erase_op_nxt = erase_op_r;
    start_nxt = 1'b0;
    unlock_nxt = unlock_r;
    idx_nxt = idx_r;
    pend_nxt = pend_r;
    pend_wr_nxt = pend_wr_r;
    act_done_nxt = act_done_r;
    addr_q_nxt = addr_q_r;
    hreadyout_nxt = hreadyout_r;
    hrdata_nxt = hrdata_r;
    mode = hwdata[OP_MODE_LSB +: 2];
    eff = (mode == MODE_PREINC) ? ptr_step(ptr_r, 1'b0) : ptr_r;
    act_fire = pend_r & ~hreadyout_r & ~act_done_r;

    // Bus: every transfer has one wait state, then extra while fetching
    if (hsel & htrans[1] & hready) begin
      pend_nxt = 1'b1;
      pend_wr_nxt = hwrite;
      addr_q_nxt = haddr[7:0];
      act_done_nxt = 1'b0;
      hreadyout_nxt = 1'b0;
    end else if (pend_r & hreadyout_r) begin
      pend_nxt = 1'b0;
    end

    if (act_fire) begin
      act_done_nxt = 1'b1;
      if (!pend_wr_r) begin
        unique case (addr_q_r)
          OFS_POINTER: hrdata_nxt = {10'h000, ptr_r};
          OFS_LATCH: hrdata_nxt = {24'h000000, latch_r};
          OFS_CONTROL: hrdata_nxt = {24'h000000, space_r, cfg_r, 1'b0, erase_sel_r, abort_r, permit_r, go_r, 1'b0};
          OFS_STATUS: hrdata_nxt = {30'h00000000, go_r, done_r};
          default: hrdata_nxt = 32'h00000000;
        endcase
      end else begin
        unlock_nxt = UNL_NONE; // R24
        unique case (addr_q_r)
          OFS_POINTER: ptr_nxt = hwdata[PTR_W-1:0];
          OFS_LATCH: latch_nxt = hwdata[7:0];
          OFS_CONTROL: begin
            space_nxt = hwdata[CTL_SPACE];
            cfg_nxt = hwdata[CTL_CFG];
            erase_sel_nxt = hwdata[CTL_ERASE];
            permit_nxt = hwdata[CTL_PERMIT];
            abort_nxt = hwdata[CTL_ABORT];
            // Go cannot be cleared by software; setting it needs the open unlock
            if (hwdata[CTL_GO] & ~go_r & (state_r == ST_IDLE) & (unlock_r == UNL_OPEN) & hwdata[CTL_PERMIT] &
                hwdata[CTL_SPACE] & ~hwdata[CTL_CFG]) begin // R20 R24
              go_nxt = 1'b1;
              erase_op_nxt = hwdata[CTL_ERASE]; // R8
              base_nxt = ptr_r;
              idx_nxt = 5'h00;
              start_nxt = 1'b1;
              state_nxt = ST_WR_ARRAY;
            end
          end
          OFS_UNLOCK: begin
            if ((hwdata[7:0] == KEY_FIRST) & permit_r) begin
              unlock_nxt = UNL_HALF;
            end else if ((hwdata[7:0] == KEY_SECOND) & (unlock_r == UNL_HALF)) begin
              unlock_nxt = UNL_OPEN;
            end
          end
          OFS_TABLE_OP: begin
            // Table ops are ignored while a long cycle owns the array
            if ((state_r == ST_IDLE) & ~go_r) begin
              unique case (mode)
                MODE_POSTINC: ptr_nxt = ptr_step(ptr_r, 1'b0); // R3 R23
                MODE_POSTDEC: ptr_nxt = ptr_step(ptr_r, 1'b1); // R23
                MODE_PREINC: ptr_nxt = eff; // R23
                MODE_KEEP: ptr_nxt = ptr_r;
              endcase
              if (hwdata[OP_LOAD]) begin
                hold_nxt[eff[2:0]] = latch_r; // R13 R22
              end else begin
                op_addr_nxt = eff;
                state_nxt = ST_FETCH;
              end
            end
          end
          OFS_STATUS: begin
            if (hwdata[ST_DONE]) begin
              done_nxt = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end

    // Sequencer
    unique case (state_r)
      ST_IDLE: ;
      ST_FETCH: state_nxt = ST_FETCH_LATCH;
      ST_FETCH_LATCH: begin
        latch_nxt = op_addr_r[0] ? mem_rd_data[15:8] : mem_rd_data[7:0]; // R1 R2
        state_nxt = ST_IDLE;
      end
      ST_WR_ARRAY: begin
        if (last_word) begin
          state_nxt = ST_WAIT;
        end else begin
          idx_nxt = idx_r + 5'h01;
        end
      end
      ST_WAIT: begin
        // Array writes finish early; the timer alone sets the cycle length
        if (timer_done) begin // R9 R10 R11
          state_nxt = ST_IDLE;
          go_nxt = 1'b0; // R20
          erase_sel_nxt = 1'b0;
          done_nxt = 1'b1; // R21
        end
      end
    endcase

    // Abort beats any software write of the flag; a completion in the same cycle still sets done
    if (abort_evt) begin
      state_nxt = ST_IDLE;
      go_nxt = 1'b0;
      abort_nxt = 1'b1; // R18
    end

    if (pend_r & ~hreadyout_r & (act_fire | act_done_r)) begin
      hreadyout_nxt = (state_nxt != ST_FETCH) & (state_nxt != ST_FETCH_LATCH);
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      ptr_r <= '0;
      op_addr_r <= '0;
      base_r <= '0;
      latch_r <= 8'h00;
      for (int i = 0; i < HOLD_N; i++) begin
        hold_r[i] <= 8'hFF;
      end
      space_r <= 1'b0;
      cfg_r <= 1'b0;
      erase_sel_r <= 1'b0;
      permit_r <= 1'b0;
      abort_r <= 1'b0;
      go_r <= 1'b0;
      done_r <= 1'b0;
      erase_op_r <= 1'b0;
      start_r <= 1'b0;
      unlock_r <= UNL_NONE;
      idx_r <= 5'h00;
      pend_r <= 1'b0;
      pend_wr_r <= 1'b0;
      act_done_r <= 1'b0;
      addr_q_r <= 8'h00;
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h00000000;
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      wdt_s1_r <= 1'b0;
      wdt_s2_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      op_addr_r <= op_addr_nxt;
      base_r <= base_nxt;
      latch_r <= latch_nxt;
      hold_r <= hold_nxt;
      space_r <= space_nxt;
      cfg_r <= cfg_nxt;
      erase_sel_r <= erase_sel_nxt;
      permit_r <= permit_nxt;
      abort_r <= abort_nxt;
      go_r <= go_nxt;
      done_r <= done_nxt;
      erase_op_r <= erase_op_nxt;
      start_r <= start_nxt;
      unlock_r <= unlock_nxt;
      idx_r <= idx_nxt;
      pend_r <= pend_nxt;
      pend_wr_r <= pend_wr_nxt;
      act_done_r <= act_done_nxt;
      addr_q_r <= addr_q_nxt;
      hreadyout_r <= hreadyout_nxt;
      hrdata_r <= hrdata_nxt;
      ext_s1_r <= ext_reset_pin_n;
      ext_s2_r <= ext_s1_r;
      wdt_s1_r <= watchdog_timeout;
      wdt_s2_r <= wdt_s1_r;
    end
  end

endmodule

// >>> tb/pfsws_checker.sv
// Bus wait and long-cycle timing checker for the flash sequencer
`timescale 1ns/1ps
module pfsws_checker #(
  parameter int PROG_CYCLES_P = 64
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic core_stall
);
  // ==========================================
  // Helper state
  logic [31:0] cnt_r, cnt_nxt;
  logic abrt_r, abrt_nxt;
  logic [2:0] age_r, age_nxt;
  logic take;
  always_comb begin
    take = hsel && htrans[1] && hready;
    cnt_nxt = core_stall ? cnt_r + 32'h1 : 32'h0;
    // Abort events may land before the synchroniser lets the stall drop
    abrt_nxt = core_stall && (abrt_r || !ext_reset_pin_n || watchdog_timeout);
    age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
    if (take && hwrite && haddr[7:0] == 8'h08) begin
      age_nxt = 3'h0;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h0;
      abrt_r <= 1'b0;
      age_r <= 3'h7;
    end else begin
      cnt_r <= cnt_nxt;
      abrt_r <= abrt_nxt;
      age_r <= age_nxt;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Properties
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_reg_wait;
    take && !(hwrite && haddr[7:0] == 8'h10) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_reg_wait: assert property (p_reg_wait) else $error("register data phase length wrong");
  property p_fetch_wait;
    take && hwrite && haddr[7:0] == 8'h10 ##1 (!hwdata[0] && !core_stall) |-> !hreadyout[*3] ##1 hreadyout;
  endproperty
  a_fetch_wait: assert property (p_fetch_wait) else $error("fetch data phase length wrong");
  property p_stall_hold;
    $rose(core_stall) |-> core_stall[*8];
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall ended early");
  property p_stall_len;
    $fell(core_stall) && !abrt_r |-> cnt_r >= PROG_CYCLES_P && cnt_r <= PROG_CYCLES_P + 4;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("long cycle length wrong");
  property p_stall_bound;
    core_stall |-> cnt_r <= PROG_CYCLES_P + 4;
  endproperty
  a_stall_bound: assert property (p_stall_bound) else $error("timer never ended stall");
  property p_pin_abort;
    !ext_reset_pin_n && core_stall |-> ##[1:6] !core_stall;
  endproperty
  a_pin_abort: assert property (p_pin_abort) else $error("pin event did not stop cycle");
  property p_wdog_abort;
    watchdog_timeout && core_stall |-> ##[1:6] !core_stall;
  endproperty
  a_wdog_abort: assert property (p_wdog_abort) else $error("watchdog did not stop cycle");
  property p_go_cause;
    $rose(core_stall) |-> age_r <= 3'h4;
  endproperty
  a_go_cause: assert property (p_go_cause) else $error("stall without control write");
endmodule

bind pfsws_top pfsws_checker #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .ext_reset_pin_n(ext_reset_pin_n),
  .watchdog_timeout(watchdog_timeout), .core_stall(core_stall));

// >>> tb/pfsws_core_model.sv
// Processor core model issuing single AHB-Lite word transfers
`timescale 1ns/1ps
module pfsws_core_model (
  input wire logic core_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // ==========================================
  // One transfer, entered just after a rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    // Released lines show junk, not the last value
    haddr <= ~{24'h0, a};
    hwdata <= w ? d : ~d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

// >>> tb/pfsws_top_tb.sv
// Self-checking bench for the program flash sequencer
`timescale 1ns/1ps
module pfsws_top_tb;
  import pfsws_pkg::*;
  localparam int P = 64;
  logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp, ext_reset_pin_n, watchdog_timeout, core_stall;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int failures, n_tests, cyc;
  pfsws_top #(.PROG_CYCLES_P(P)) uut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_reset_pin_n(ext_reset_pin_n),
    .watchdog_timeout(watchdog_timeout), .core_stall(core_stall));
  pfsws_core_model core (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ==========================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    core.xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    core.xfer(a, 1'b0, 32'h0, q);
    chk(nm, q, exp);
  endtask
  task automatic fetch(input logic [1:0] m, input logic [7:0] exp, input string nm);
    wr(OFS_TABLE_OP, {29'h0, m, 1'b0});
    rd(OFS_LATCH, {24'h0, exp}, nm);
  endtask
  task automatic unlock_go(input logic [31:0] c);
    wr(OFS_UNLOCK, {24'h0, KEY_FIRST});
    wr(OFS_UNLOCK, {24'h0, KEY_SECOND});
    wr(OFS_CONTROL, c | 32'h2);
  endtask
  // Polls status; the bus stays usable during a long cycle
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      core.xfer(OFS_STATUS, 1'b0, 32'h0, q);
      k++;
    end while (q[ST_BUSY] !== 1'b0 && k < 100);
    chk("idle wait", {31'h0, q[ST_BUSY]}, 32'h0);
  endtask
  task automatic test_done;
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    ext_reset_pin_n = 1'b1;
    watchdog_timeout = 1'b0;
    failures = 0;
    n_tests = 0;
    cyc = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(OFS_CONTROL, 32'h0, "ctl reset");
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, 32'h0, "unmapped");
    wr(OFS_POINTER, 32'h47);
    wr(OFS_CONTROL, 32'h94);
    unlock_go(32'h94);
    wait_idle();
    rd(OFS_CONTROL, 32'h84, "ctl after erase");
    rd(OFS_STATUS, 32'h1, "done after erase");
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, 32'h0, "done cleared");
    wr(OFS_POINTER, 32'h3F);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_LATCH, 32'h50 + i);
      wr(OFS_TABLE_OP, {29'h0, MODE_PREINC, 1'b1});
    end
    rd(OFS_POINTER, 32'h47, "ptr after loads");
    fetch(MODE_KEEP, 8'hFF, "array untouched by loads");
    wr(OFS_CONTROL, 32'h84);
    unlock_go(32'h84);
    wait_idle();
    wr(OFS_STATUS, 32'h1);
    wr(OFS_POINTER, 32'h40);
    for (int i = 0; i < 8; i++) begin
      fetch(MODE_POSTINC, 8'h50 + i[7:0], "programmed byte");
    end
    fetch(MODE_POSTDEC, 8'hFF, "next group erased");
    fetch(MODE_KEEP, 8'h57, "keep fetch");
    rd(OFS_POINTER, 32'h47, "ptr after keep");
    wr(OFS_CONTROL, 32'h86);
    rd(OFS_STATUS, 32'h0, "go without unlock");
    wr(OFS_UNLOCK, {24'h0, KEY_FIRST});
    wr(OFS_POINTER, 32'h40);
    wr(OFS_UNLOCK, {24'h0, KEY_SECOND});
    wr(OFS_CONTROL, 32'h86);
    rd(OFS_CONTROL, 32'h84, "go after broken unlock");
    for (int k = 0; k < 2; k++) begin
      wr(OFS_CONTROL, 32'h84);
      unlock_go(32'h84);
      repeat (12) @(posedge core_clk);
      ext_reset_pin_n <= (k != 0);
      watchdog_timeout <= (k == 1);
      repeat (3) @(posedge core_clk);
      ext_reset_pin_n <= 1'b1;
      watchdog_timeout <= 1'b0;
      wait_idle();
      rd(OFS_CONTROL, 32'h8C, "abort flag");
      rd(OFS_STATUS, 32'h0, "no done on abort");
    end
    // Cut write leaves the block suspect; program it again and read back
    unlock_go(32'h84);
    wait_idle();
    rd(OFS_STATUS, 32'h1, "done after reprogram");
    rd(OFS_CONTROL, 32'h84, "abort cleared by go write");
    fetch(MODE_KEEP, 8'h50, "reprogrammed byte");
    test_done();
  end
endmodule
